// ===== core/fcs_sequencer.sv
// host-side chip erase and byte write sequencer for a parallel flash memory
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int ERASE_COUNT = ERASE_PULSES,
  parameter int WRITE_COUNT = WRITE_PULSES,
  parameter bit VPP_SWITCHED = 1'b1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command side
  input wire logic cmd_valid,
  input wire fcs_cmd_t cmd,
  output logic cmd_ready,
  output logic busy,
  output logic done,
  // memory pins
  output fcs_pins_t pins
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_SELECT = 6'b000100,
    ST_STROBE = 6'b001000,
    ST_RECOV = 6'b010000,
    ST_RELEASE = 6'b100000
  } fcs_state_t;

  localparam logic [TIMER_W-1:0] STROBE_LOAD = TIMER_W'(STROBE_CYC);
  localparam logic [TIMER_W-1:0] SETUP_LOAD = TIMER_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_COUNT);
  localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_COUNT);

  // one-cold select of a single memory
  function automatic logic [CHIPS-1:0] chip_sel(input logic [CHIP_W-1:0] c);
    logic [CHIPS-1:0] v;
    v = {CHIPS{1'b1}};
    v[c] = 1'b0;
    return v;
  endfunction

  fcs_state_t state;
  fcs_state_t next_state;
  fcs_cmd_t job;
  fcs_cmd_t next_job;
  fcs_pins_t next_pins;
  logic [CNT_W-1:0] pulses;
  logic [CNT_W-1:0] next_pulses;
  logic next_cmd_ready;
  logic next_busy;
  logic next_done;
  logic tmr_start;
  logic [TIMER_W-1:0] tmr_load;
  logic tmr_expired;

  ////////////////////////////////////////////////////////////////////////
  fcs_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .load(tmr_load),
    .expired(tmr_expired),
    .running()
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_job = job;
    next_pins = pins;
    next_pulses = pulses;
    next_done = 1'b0;
    tmr_start = 1'b0;
    tmr_load = SETUP_LOAD;
    case (state)
      ST_IDLE:
      begin
        if (cmd_valid && cmd_ready)
        begin
          next_job = cmd;
          if (cmd.op == FCS_OP_WRITE && cmd.data == ERASED_BYTE)
          begin
            next_done = 1'b1;
          end
          else
          begin
            next_pins.vpp_on = VPP_SWITCHED;
            next_pins.read_drive_n = 1'b1;
            next_pins.erase_select_line_one = (cmd.op == FCS_OP_ERASE);
            next_pins.erase_select_line_two = (cmd.op == FCS_OP_ERASE);
            next_pins.erase_select_line_three = (cmd.op == FCS_OP_ERASE);
            if (cmd.op == FCS_OP_ERASE)
            begin
              next_pins.addr = ERASE_ADDR_HI;
              next_pins.erase_half_select = 1'b1;
              next_pins.data_oe = 1'b0;
            end
            else
            begin
              next_pins.addr = cmd.addr;
              next_pins.data = cmd.data;
              next_pins.data_oe = 1'b1;
              next_pins.erase_half_select = 1'b0;
            end
            next_pulses = '0;
            tmr_start = 1'b1;
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP:
      begin
        if (tmr_expired)
        begin
          next_pins.chip_select_n = chip_sel(job.chip);
          next_state = ST_SELECT;
        end
      end
      ST_SELECT:
      begin
        next_pins.program_strobe_n = 1'b0;
        tmr_start = 1'b1;
        tmr_load = STROBE_LOAD;
        next_state = ST_STROBE;
      end
      ST_STROBE:
      begin
        if (tmr_expired)
        begin
          next_pins.program_strobe_n = 1'b1;
          next_pulses = pulses + 1'b1;
          tmr_start = 1'b1;
          next_state = ST_RECOV;
        end
      end
      ST_RECOV:
      begin
        if (tmr_expired)
        begin
          if (pulses != ((job.op == FCS_OP_ERASE) ? ERASE_LAST : WRITE_LAST))
          begin
            next_pins.program_strobe_n = 1'b0;
            tmr_start = 1'b1;
            tmr_load = STROBE_LOAD;
            next_state = ST_STROBE;
          end
          else if (job.op == FCS_OP_ERASE && pins.erase_half_select)
          begin
            next_pins.erase_half_select = 1'b0;
            next_pins.addr = ERASE_ADDR_LO;
            next_pins.chip_select_n = {CHIPS{1'b1}};
            next_pulses = '0;
            tmr_start = 1'b1;
            next_state = ST_SETUP;
          end
          else
          begin
            next_pins.chip_select_n = {CHIPS{1'b1}};
            next_pins.vpp_on = 1'b0;
            next_pins.erase_select_line_one = 1'b0;
            next_pins.erase_select_line_two = 1'b0;
            next_pins.erase_select_line_three = 1'b0;
            next_pins.data_oe = 1'b0;
            tmr_start = 1'b1;
            next_state = ST_RELEASE;
          end
        end
      end
      ST_RELEASE:
      begin
        if (tmr_expired)
        begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_pins = PINS_RST;
      end
    endcase
    next_cmd_ready = (next_state == ST_IDLE);
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      job <= '0;
      pins <= PINS_RST;
      pulses <= '0;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      job <= next_job;
      pins <= next_pins;
      pulses <= next_pulses;
      cmd_ready <= next_cmd_ready;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule

// ===== core/fcs_pkg.sv
// constants, timing and carrier types for the flash erase/write sequencer
package fcs_pkg;
  // widths of the memory side
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CHIPS = 2;
  localparam int CHIP_W = 1;
  // clock and documented times
  localparam int CLK_MHZ = 40;
  localparam int STROBE_US = 100;
  localparam int STROBE_MIN_US = 90;
  localparam int STROBE_MAX_US = 120;
  localparam int SETUP_US = 2;
  localparam int STROBE_CYC = STROBE_US * CLK_MHZ;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int TIMER_W = 12;
  // pulse counts
  localparam int ERASE_PULSES = 100000;
  localparam int WRITE_PULSES = 20;
  localparam int CNT_W = 17;
  // erase dummy addresses, erased value and bus reset values
  localparam logic [ADDR_W-1:0] ERASE_ADDR_HI = 16'h00FF;
  localparam logic [ADDR_W-1:0] ERASE_ADDR_LO = 16'h00F7;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [0:0] {
    FCS_OP_ERASE = 1'b0,
    FCS_OP_WRITE = 1'b1
  } fcs_op_t;

  typedef struct packed {
    fcs_op_t op;
    logic [CHIP_W-1:0] chip;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcs_cmd_t;

  typedef struct packed {
    logic vpp_on;
    logic erase_select_line_one;
    logic erase_select_line_two;
    logic erase_select_line_three;
    logic erase_half_select;
    logic read_drive_n;
    logic program_strobe_n;
    logic [CHIPS-1:0] chip_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic data_oe;
  } fcs_pins_t;

  localparam fcs_pins_t PINS_RST = '{
    vpp_on: 1'b0,
    erase_select_line_one: 1'b0,
    erase_select_line_two: 1'b0,
    erase_select_line_three: 1'b0,
    erase_half_select: 1'b0,
    read_drive_n: 1'b1,
    program_strobe_n: 1'b1,
    chip_select_n: {CHIPS{1'b1}},
    addr: ADDR_RST,
    data: DATA_RST,
    data_oe: 1'b0
  };
endpackage

// ===== core/fcs_timer.sv
// down counter that times strobe and settle intervals
module fcs_timer
  import fcs_pkg::*;
#(
  parameter int W = TIMER_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // load side
  input wire logic start,
  input wire logic [W-1:0] load,
  // state
  output logic expired,
  output logic running
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_cnt = cnt;
    if (start)
    begin
      next_cnt = load;
    end
    else if (cnt != '0)
    begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

  // expiry falls in the last counted cycle
  assign expired = (cnt == {{(W-1){1'b0}}, 1'b1});
  assign running = (cnt != '0);
endmodule

// ===== verification/fcs_sequencer_props.sv
// assertions on the sequencer ports
module fcs_sequencer_props
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command side
  input wire logic cmd_valid,
  input wire fcs_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic busy,
  input wire logic done,
  // memory pins
  input wire fcs_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  logic pgm;
  logic [12:0] lo_cnt;
  logic [12:0] hi_cnt;
  logic [12:0] next_lo_cnt;
  logic [12:0] next_hi_cnt;
  assign pgm = !pins.program_strobe_n;
  always_comb
  begin
    next_lo_cnt = pgm ? lo_cnt + 13'h1 : 13'h0;
    next_hi_cnt = 13'h0;
    if (!pgm && pins.vpp_on)
      next_hi_cnt = hi_cnt + {12'h0, hi_cnt != 13'h1FFF};
  end
  always_ff @(posedge clk)
  begin
    lo_cnt <= rst ? 13'h0 : next_lo_cnt;
    hi_cnt <= rst ? 13'h0 : next_hi_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_pulse_end;
    $rose(pins.program_strobe_n);
  endsequence
  chk_strobe_width: assert property (s_pulse_end |-> lo_cnt == STROBE_CYC)
    else $error("strobe width wrong");
  chk_strobe_setup: assert property ($fell(pins.program_strobe_n) |-> hi_cnt >= SETUP_CYC)
    else $error("setup before strobe too short");
  chk_strobe_cond: assert property (pgm |-> pins.vpp_on && pins.chip_select_n != '1)
    else $error("strobe without supply or select");
  chk_select_one: assert property ($onehot0(~pins.chip_select_n))
    else $error("more than one chip selected");
  chk_read_high: assert property (pins.read_drive_n)
    else $error("read drive asserted");
  chk_stable_bus: assert property (pgm |-> $stable(pins.addr) && $stable(pins.data))
    else $error("address or data moved under strobe");
  chk_erase_lines: assert property (pgm && !pins.data_oe |-> pins.erase_select_line_one
    && pins.erase_select_line_two && pins.erase_select_line_three
    && pins.erase_half_select == pins.addr[3])
    else $error("erase lines wrong under strobe");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_take_busy: assert property (s_take |=> busy || done)
    else $error("command taken without effect");
  chk_done_rest: assert property (done |-> !pins.vpp_on && pins.chip_select_n == '1
    && !pins.erase_select_line_one)
    else $error("high voltage left on at done");
endmodule

// ===== verification/fcs_flash_model.sv
// behavioural model of the flash memories on the shared pins
module fcs_flash_model
  import fcs_pkg::*;
(
  // clock
  input wire logic clk,
  // memory pins
  input wire fcs_pins_t pins,
  // observed results
  output logic [CHIPS-1:0][7:0] er_hi,
  output logic [CHIPS-1:0][7:0] er_lo,
  output logic [CHIPS-1:0][7:0] wr_n,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_n;
  logic ers;
  assign ers = pins.vpp_on && pins.erase_select_line_one
    && pins.erase_select_line_two && pins.erase_select_line_three;
  initial
  begin
    {er_hi, er_lo, wr_n, wr_addr, wr_data} = '0;
    last_n = 1'b1;
  end
  always @(negedge clk)
  begin
    for (int c = 0; c < CHIPS; c++)
      if (!last_n && pins.program_strobe_n && !pins.chip_select_n[c])
        if (ers && pins.erase_half_select) er_hi[c] += 8'h01;
        else if (ers) er_lo[c] += 8'h01;
        else if (pins.vpp_on && pins.data_oe)
        begin
          wr_n[c] += 8'h01;
          wr_addr = pins.addr;
          wr_data = pins.data;
        end
    last_n = pins.program_strobe_n;
  end
endmodule

// ===== verification/tb_fcs_sequencer.sv
// testbench for the flash erase/write sequencer
module tb_fcs_sequencer
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, cmd_valid, cmd_ready, busy, done;
  fcs_cmd_t cmd;
  fcs_pins_t pins;
  logic [CHIPS-1:0][7:0] er_hi, er_lo, wr_n;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  int bad_count = 0;
  int n_tests = 0;
  fcs_sequencer #(.ERASE_COUNT(3), .WRITE_COUNT(2), .VPP_SWITCHED(1'b1))
    fcs_sequencer_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .busy(busy), .done(done), .pins(pins));
  fcs_flash_model fcs_flash_model_i (.clk(clk), .pins(pins), .er_hi(er_hi),
    .er_lo(er_lo), .wr_n(wr_n), .wr_addr(wr_addr), .wr_data(wr_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic run(input fcs_cmd_t c, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 100);
    check(cmd_ready, 1'b1);
    cmd = c;
    cmd_valid = 1'b1;
    n = 0;
    @(posedge clk);
    #1;
    check(busy | done, 1'b1);
    while (done !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      cmd_valid = 1'b0;
      @(posedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    check(n < lim, 1'b1);
    check(busy, 1'b0);
  endtask
  task automatic test_erase;
    int n;
    run('{FCS_OP_ERASE, 1'b0, 16'h0000, 8'h00}, 30000, n);
    check(er_hi[0], 32'h3);
    check(er_lo[0], 32'h3);
    check(er_hi[1] | er_lo[1], 32'h0);
    $display("test erase done");
  endtask
  task automatic test_write;
    int n;
    run('{FCS_OP_WRITE, 1'b0, 16'h1234, 8'h5A}, 12000, n);
    check(wr_n[0], 32'h2);
    check(wr_addr, 32'h1234);
    check(wr_data, 32'h5A);
    check(wr_n[1] | er_lo[1], 32'h0);
    $display("test write done");
  endtask
  task automatic test_skip;
    int n;
    run('{FCS_OP_WRITE, 1'b0, 16'h0040, 8'hFF}, 10, n);
    check(n, 32'h0);
    check(wr_n[0], 32'h2);
    $display("test skip done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #1500000;
    bad_count++;
    report_and_stop;
  end
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(pins === PINS_RST, 1'b1);
    test_erase;
    test_write;
    test_skip;
    report_and_stop;
  end
endmodule
bind fcs_sequencer fcs_sequencer_props fcs_sequencer_props_i (.clk(clk),
  .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .busy(busy), .done(done), .pins(pins));
